/* verilog/asp_pkg.sv */
// ****************************************************************
// Serial port and data-ready constants
// ****************************************************************
package asp_pkg;

    // Register widths in bits
    localparam logic [4:0] COMM_W      = 5'h08;
    localparam logic [4:0] SETUP_W     = 5'h08;
    localparam logic [4:0] TEST_W      = 5'h08;
    localparam logic [4:0] DATA_W      = 5'h10;

    // Register select codes
    localparam logic [1:0] RS_COMM     = 2'h0;
    localparam logic [1:0] RS_SETUP    = 2'h1;
    localparam logic [1:0] RS_TEST     = 2'h2;
    localparam logic [1:0] RS_DATA     = 2'h3;

    // Communications byte field positions
    localparam int         RS_HI       = 5;
    localparam int         RS_LO       = 4;
    localparam int         RW_BIT      = 3;
    localparam int         STBY_BIT    = 2;
    localparam int         GAIN_HI     = 1;
    localparam int         GAIN_LO     = 0;

    // Timing counts
    localparam int         HOLD_MCLK   = 500;
    localparam logic [5:0] RESYNC_ONES = 6'h20;

    // Port, pin and control carriers
    typedef struct packed {
        logic       standby;
        logic [1:0] gain;
        logic [7:0] setup;
    } asp_ctrl_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
        logic mclk;
    } asp_pins_t;

    // Reset values
    localparam asp_ctrl_t  CTRL_RST    = 11'h000;
    localparam logic [3:0] PIN_IDLE    = 4'hc;

    typedef enum logic [2:0] {
        SP_COMM  = 3'b001,
        SP_WRITE = 3'b010,
        SP_READ  = 3'b100
    } asp_ser_t;

    typedef enum logic [2:0] {
        DR_EMPTY = 3'b001,
        DR_AVAIL = 3'b010,
        DR_HOLD  = 3'b100
    } asp_rdy_t;

endpackage : asp_pkg

/* verilog/asp_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// Two-stage synchroniser
// ****************************************************************
module asp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST;
            q      <= RST;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : asp_sync

/* verilog/asp_count.sv */
`timescale 1ns/1ps
// ****************************************************************
// Tick counter with done pulse
// ****************************************************************
module asp_count #(
    parameter int N = 500
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    input  wire logic tick,
    output logic      done
);

    localparam int CW = $clog2(N + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          busy_q;
    logic          busy_d;

    // Done on the N-th tick after start
    assign done = busy_q & tick & (cnt_q == CW'(N - 1));

    // Next count; a restart while busy begins again from zero
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        if (start) begin
            cnt_d  = '0;
            busy_d = 1'b1;
        end else if (done) begin
            cnt_d  = '0;
            busy_d = 1'b0;
        end else if (busy_q && tick) begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    // Count registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
        end
    end

endmodule : asp_count

/* verilog/asp_serial_port.sv */
`timescale 1ns/1ps
module asp_serial_port (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Serial pins
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    input  wire logic                   din,
    output logic                        dout,
    output logic                        dout_oe,
    output logic                        data_ready_n,
    // Master clock pins
    input  wire logic                   mclk_in,
    output logic                        mclk_out,
    // Converter core side
    input  wire logic                   conv_valid,
    input  wire logic [15:0]            conv_word,
    input  wire logic                   cal_done,
    output asp_pkg::asp_ctrl_t          ctrl,
    output logic                        core_reset
);

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic               rst_meta_q;
    logic               rst_n_q;
    asp_pkg::asp_pins_t pins;

    // Async assert, clocked release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    asp_sync #(
        .W   (4),
        .RST (asp_pkg::PIN_IDLE)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n_q),
        .d     ({sclk, cs_n, din, mclk_in}),
        .q     (pins)
    );

    // ****************************************************************
    // Serial shift engine
    // ****************************************************************
    asp_pkg::asp_ser_t  ser_q,       ser_d;
    asp_pkg::asp_ctrl_t ctrl_q,      ctrl_d;
    logic [4:0]         bit_cnt_q,   bit_cnt_d;
    logic [5:0]         ones_q,      ones_d;
    logic [15:0]        shin_q,      shin_d;
    logic [15:0]        out_sh_q,    out_sh_d;
    logic [1:0]         rs_q,        rs_d;
    logic               rw_q,        rw_d;
    logic               rd_done_q,   rd_done_d;
    logic               sclk_prev_q;
    logic               dout_q,      dout_d;
    logic               dout_oe_q,   oe_d;
    logic               data_ready_n_q;
    logic [15:0]        data_q;
    logic               sclk_rise;
    logic               sclk_fall;

    // Edges found at clk rate; host may stop the clock between bytes
    assign sclk_rise = pins.sclk & ~sclk_prev_q;
    assign sclk_fall = ~pins.sclk & sclk_prev_q;

    function automatic logic [4:0] reg_width(input logic [1:0] rs);
        case (rs)
            asp_pkg::RS_COMM:  reg_width = asp_pkg::COMM_W;
            asp_pkg::RS_SETUP: reg_width = asp_pkg::SETUP_W;
            asp_pkg::RS_TEST:  reg_width = asp_pkg::TEST_W;
            default:           reg_width = asp_pkg::DATA_W;
        endcase
    endfunction : reg_width

    // Read source, MSB aligned; test register reads as zero
    function automatic logic [15:0] read_src(input logic [1:0] rs);
        case (rs)
            asp_pkg::RS_COMM:  read_src = {data_ready_n_q, 1'b0, rs_q, rw_q, ctrl_q.standby, ctrl_q.gain, 8'h00};
            asp_pkg::RS_SETUP: read_src = {ctrl_q.setup, 8'h00};
            asp_pkg::RS_DATA:  read_src = data_q;
            default:           read_src = 16'h0000;
        endcase
    endfunction : read_src

    // Next state of the shift engine
    always_comb begin
        ser_d     = ser_q;
        bit_cnt_d = bit_cnt_q;
        ones_d    = ones_q;
        shin_d    = shin_q;
        out_sh_d  = out_sh_q;
        rs_d      = rs_q;
        rw_d      = rw_q;
        ctrl_d    = ctrl_q;
        rd_done_d = 1'b0;
        oe_d      = ~pins.cs_n;
        if (pins.cs_n) begin
            // Deselect ends the frame; a partial word restarts next frame
            bit_cnt_d = '0;
            if (ser_q == asp_pkg::SP_READ) begin
                out_sh_d = read_src(rs_q);
            end
        end else if (sclk_rise) begin
            shin_d    = {shin_q[14:0], pins.din};
            bit_cnt_d = bit_cnt_q + 5'h01;
            ones_d    = pins.din ? ones_q + 6'h01 : 6'h00;
            case (ser_q)
                asp_pkg::SP_COMM: begin
                    if (bit_cnt_q == 5'h00 && pins.din) begin
                        bit_cnt_d = '0;
                    end else if (bit_cnt_q == asp_pkg::COMM_W - 5'h01) begin
                        rs_d           = shin_d[asp_pkg::RS_HI:asp_pkg::RS_LO];
                        rw_d           = shin_d[asp_pkg::RW_BIT];
                        ctrl_d.standby = shin_d[asp_pkg::STBY_BIT];
                        ctrl_d.gain    = shin_d[asp_pkg::GAIN_HI:asp_pkg::GAIN_LO];
                        bit_cnt_d      = '0;
                        if (rw_d) begin
                            ser_d    = asp_pkg::SP_READ;
                            out_sh_d = read_src(rs_d);
                            // Comm readback shows the byte just taken, not the one before
                            if (rs_d == asp_pkg::RS_COMM) begin
                                out_sh_d = {data_ready_n_q, 1'b0, shin_d[asp_pkg::RS_HI:asp_pkg::GAIN_LO], 8'h00};
                            end
                        end else begin
                            ser_d = asp_pkg::SP_WRITE;
                        end
                    end
                end
                asp_pkg::SP_WRITE: begin
                    // Target updates only once the full width is in
                    if (bit_cnt_q == reg_width(rs_q) - 5'h01) begin
                        bit_cnt_d = '0;
                        ser_d     = asp_pkg::SP_COMM;
                        if (rs_q == asp_pkg::RS_SETUP) begin
                            ctrl_d.setup = shin_d[7:0];
                        end else if (rs_q == asp_pkg::RS_COMM) begin
                            rs_d           = shin_d[asp_pkg::RS_HI:asp_pkg::RS_LO];
                            rw_d           = shin_d[asp_pkg::RW_BIT];
                            ctrl_d.standby = shin_d[asp_pkg::STBY_BIT];
                            ctrl_d.gain    = shin_d[asp_pkg::GAIN_HI:asp_pkg::GAIN_LO];
                        end
                    end
                end
                asp_pkg::SP_READ: begin
                    if (bit_cnt_q == reg_width(rs_q) - 5'h01) begin
                        bit_cnt_d = '0;
                        ser_d     = asp_pkg::SP_COMM;
                        out_sh_d  = '0;
                        rd_done_d = (rs_q == asp_pkg::RS_DATA);
                    end
                end
                default: begin
                    ser_d     = asp_pkg::SP_COMM;
                    bit_cnt_d = '0;
                end
            endcase
            // A long run of ones brings a lost interface back to its start
            if (ones_q == asp_pkg::RESYNC_ONES - 6'h01 && pins.din) begin
                ser_d     = asp_pkg::SP_COMM;
                bit_cnt_d = '0;
                ones_d    = '0;
                out_sh_d  = '0;
                rd_done_d = 1'b0;
            end
        end else if (sclk_fall && ser_q == asp_pkg::SP_READ && bit_cnt_q != 5'h00) begin
            // First fall of a read keeps the MSB out for the host's first rise
            out_sh_d = {out_sh_q[14:0], 1'b0};
        end
        dout_d = out_sh_d[15];
    end

    // Shift engine registers
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ser_q       <= asp_pkg::SP_COMM;
            ctrl_q      <= asp_pkg::CTRL_RST;
            bit_cnt_q   <= '0;
            ones_q      <= '0;
            shin_q      <= '0;
            out_sh_q    <= '0;
            rs_q        <= asp_pkg::RS_COMM;
            rw_q        <= 1'b0;
            rd_done_q   <= 1'b0;
            sclk_prev_q <= 1'b1;
            dout_q      <= 1'b0;
            dout_oe_q   <= 1'b0;
        end else begin
            ser_q       <= ser_d;
            ctrl_q      <= ctrl_d;
            bit_cnt_q   <= bit_cnt_d;
            ones_q      <= ones_d;
            shin_q      <= shin_d;
            out_sh_q    <= out_sh_d;
            rs_q        <= rs_d;
            rw_q        <= rw_d;
            rd_done_q   <= rd_done_d;
            sclk_prev_q <= pins.sclk;
            dout_q      <= dout_d;
            dout_oe_q   <= oe_d;
        end
    end

    // ****************************************************************
    // Data-ready handshake and master clock
    // ****************************************************************
    asp_pkg::asp_rdy_t rdy_q,  rdy_d;
    logic [15:0]       data_d;
    logic [15:0]       pend_q, pend_d;
    logic [9:0]        ticks_q, ticks_d;
    logic              ready_n_d;
    logic              mclk_prev_q;
    logic              mclk_out_q;
    logic              core_reset_q;
    logic              mclk_tick;
    logic              hold_start;
    logic              hold_done;

    assign mclk_tick = pins.mclk & ~mclk_prev_q;

    asp_count #(
        .N (asp_pkg::HOLD_MCLK)
    ) u_hold (
        .clk   (clk),
        .rst_n (rst_n_q),
        .start (hold_start),
        .tick  (mclk_tick),
        .done  (hold_done)
    );

    // Next data-ready state; a newer word during the hold replaces the pending one
    always_comb begin
        rdy_d      = rdy_q;
        data_d     = data_q;
        pend_d     = pend_q;
        hold_start = 1'b0;
        ticks_d    = (rdy_q == asp_pkg::DR_HOLD) ? ticks_q + {9'h000, mclk_tick} : 10'h000;
        case (rdy_q)
            asp_pkg::DR_EMPTY: begin
                if (conv_valid) begin
                    data_d = conv_word;
                    rdy_d  = asp_pkg::DR_AVAIL;
                end else if (cal_done) begin
                    rdy_d = asp_pkg::DR_AVAIL;
                end
            end
            asp_pkg::DR_AVAIL: begin
                if (rd_done_q) begin
                    if (conv_valid) begin
                        data_d = conv_word;
                    end else begin
                        rdy_d = asp_pkg::DR_EMPTY;
                    end
                end else if (conv_valid) begin
                    pend_d     = conv_word;
                    hold_start = 1'b1;
                    rdy_d      = asp_pkg::DR_HOLD;
                end
            end
            asp_pkg::DR_HOLD: begin
                // In this state the data register takes the pending word only when the hold ends, while the host stays off
                if (conv_valid) begin
                    pend_d = conv_word;
                end
                if (hold_done) begin
                    data_d = pend_d;
                    rdy_d  = asp_pkg::DR_AVAIL;
                end
            end
            default: rdy_d = asp_pkg::DR_EMPTY;
        endcase
        ready_n_d = (rdy_d != asp_pkg::DR_AVAIL);
    end

    // Data-ready registers; the inverted clock lags the pin by the synchroniser and one more register
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdy_q          <= asp_pkg::DR_EMPTY;
            data_q         <= '0;
            pend_q         <= '0;
            ticks_q        <= '0;
            data_ready_n_q <= 1'b1;
            mclk_prev_q    <= 1'b0;
            mclk_out_q     <= 1'b1;
            core_reset_q   <= 1'b1;
        end else begin
            rdy_q          <= rdy_d;
            data_q         <= data_d;
            pend_q         <= pend_d;
            ticks_q        <= ticks_d;
            data_ready_n_q <= ready_n_d;
            mclk_prev_q    <= pins.mclk;
            mclk_out_q     <= ~pins.mclk;
            core_reset_q   <= 1'b0;
        end
    end

    // Outputs
    assign dout         = dout_q;
    assign dout_oe      = dout_oe_q;
    assign data_ready_n = data_ready_n_q;
    assign mclk_out     = mclk_out_q;
    assign ctrl         = ctrl_q;
    assign core_reset   = core_reset_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    sequence s_data_read;
        rdy_q == asp_pkg::DR_AVAIL && rd_done_q && !conv_valid;
    endsequence

    sequence s_unread_update;
        rdy_q == asp_pkg::DR_AVAIL && conv_valid && !rd_done_q;
    endsequence

    a_core_reset_drop: assert property ($fell(core_reset_q) |-> ser_q == asp_pkg::SP_COMM && data_ready_n_q)
        else $error("core not released from reset state");
    a_word_avail: assert property (rdy_q == asp_pkg::DR_EMPTY && conv_valid |=> !data_ready_n_q && data_q == $past(conv_word))
        else $error("new word not flagged");
    a_ready_after_read: assert property (s_data_read |=> data_ready_n_q)
        else $error("data ready not raised after read");
    a_hold_enter: assert property (s_unread_update |=> data_ready_n_q && rdy_q == asp_pkg::DR_HOLD)
        else $error("hold not entered on unread update");
    a_hold_width: assert property (rdy_q == asp_pkg::DR_HOLD && hold_done |-> ticks_q == 10'(asp_pkg::HOLD_MCLK - 1))
        else $error("hold length wrong");
    a_fresh_low: assert property ($fell(data_ready_n_q) |-> $past(conv_valid) || $past(cal_done) || $past(hold_done))
        else $error("data ready fell without update");
    a_cal_flag: assert property (rdy_q == asp_pkg::DR_EMPTY && cal_done && !conv_valid |=> !data_ready_n_q)
        else $error("calibration end not flagged");
    a_read_load: assert property (ser_q == asp_pkg::SP_COMM && ser_d == asp_pkg::SP_READ && rs_d == asp_pkg::RS_DATA |=> out_sh_q == $past(data_q))
        else $error("data word not loaded for read");
    a_setup_write: assert property ($changed(ctrl_q.setup) |-> $past(ser_q) == asp_pkg::SP_WRITE && $past(rs_q) == asp_pkg::RS_SETUP)
        else $error("setup changed outside a setup write");
    a_mclk_inverse: assert property (pins.mclk [*2] |-> !mclk_out_q)
        else $error("master clock output not inverted");
    a_comm_wait: assert property (ser_q == asp_pkg::SP_COMM && bit_cnt_q == 5'h00 && sclk_rise && pins.din && !pins.cs_n |=> ser_q == asp_pkg::SP_COMM && bit_cnt_q == 5'h00)
        else $error("leading one not ignored");
    a_full_word: assert property (rd_done_q |-> $past(bit_cnt_q) == asp_pkg::DATA_W - 5'h01 && $past(sclk_rise))
        else $error("read done before full word");
    a_deselect_oe: assert property (pins.cs_n |=> !dout_oe_q)
        else $error("output enabled while deselected");

endmodule : asp_serial_port

/* tb/asp_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host serial port model
// ****************************************************************
module asp_host_model (
    // Serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    // Idle: clock high and still, device not selected
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b1;
    end
    // Comm byte first, then n bits MSB first; keep_sel leaves select low (three-wire use)
    task automatic frame(input logic [7:0] comm, input logic [15:0] tx, input int n,
                         input logic keep_sel, output logic [15:0] rx);
        logic [23:0] sh;
        sh   = {comm, 16'h0000} | (24'(tx) << (16 - n));
        rx   = 16'h0000;
        cs_n = 1'b0;
        #300;
        for (int i = 0; i < 8 + n; i++) begin
            sclk = 1'b0;
            din  = sh[23];
            sh   = sh << 1;
            #100;
            rx   = {rx[14:0], dout};
            sclk = 1'b1;
            #100;
        end
        #300;
        din = ~din;                                        // Released line shows no stale level
        if (!keep_sel) begin
            cs_n = 1'b1;
        end
        #300;
    endtask : frame
endmodule : asp_host_model

/* tb/adc_serial_port_ready_logic_tb.sv */
`timescale 1ns/1ps
module adc_serial_port_ready_logic_tb;
    // ****************************************************************
    // Stimulus and observation
    // ****************************************************************
    logic               clk        = 1'b0;
    logic               reset_n    = 1'b0;
    logic               mclk_in    = 1'b0;
    logic               conv_valid = 1'b0;
    logic [15:0]        conv_word  = 16'h0000;
    logic               cal_done   = 1'b0;
    logic               sclk, cs_n, din, dout, dout_oe, dout_line, data_ready_n, mclk_out, core_reset;
    asp_pkg::asp_ctrl_t ctrl;
    logic [15:0]        rx;
    int                 errors     = 0;
    int                 compares   = 0;
    int                 cnt;
    // 40 MHz system clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // 2 MHz master clock, phase unrelated to clk
    initial begin
        #3.3;
        forever #250 mclk_in = ~mclk_in;
    end
    asp_serial_port asp_serial_port_inst (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .data_ready_n(data_ready_n), .mclk_in(mclk_in), .mclk_out(mclk_out),
        .conv_valid(conv_valid), .conv_word(conv_word), .cal_done(cal_done), .ctrl(ctrl), .core_reset(core_reset));
    // Undriven output reads back inverted so a stale level cannot pass
    assign dout_line = dout_oe ? dout : ~dout;
    asp_host_model asp_host_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_line));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    // One-cycle core pulse, sampled one edge later; returns after the answer edge
    task automatic pulse(input logic cal, input logic [15:0] w);
        @(posedge clk);
        conv_valid <= !cal;
        cal_done   <= cal;
        conv_word  <= w;
        @(posedge clk);
        conv_valid <= 1'b0;
        cal_done   <= 1'b0;
        @(posedge clk);
        #1;
    endtask : pulse
    // Fresh word read whole, framed or three-wire
    task automatic t_read(input logic [15:0] w, input logic three_wire);
        pulse(1'b0, w);
        chk(data_ready_n, 1'b0);
        asp_host_model_inst.frame(8'h38, 16'h0000, 16, three_wire, rx);
        chk(rx, w);
        chk(data_ready_n, 1'b1);
        chk(dout_oe, three_wire);
    endtask : t_read
    // Setup write then readback, then a cut-short write
    task automatic t_setup();
        asp_host_model_inst.frame(8'h10, 16'h00a5, 8, 1'b0, rx);
        chk(ctrl.setup, 8'ha5);
        asp_host_model_inst.frame(8'h18, 16'h0000, 8, 1'b0, rx);
        chk(rx[7:0], 8'ha5);
        asp_host_model_inst.frame(8'hff, 16'h0a00, 16, 1'b0, rx);
        chk(rx, 16'h008a);
        chk(ctrl.gain, 2'h2);
        asp_host_model_inst.frame(8'h10, 16'h0005, 4, 1'b0, rx);
        chk(ctrl.setup, 8'ha5);
    endtask : t_setup
    // Unread word: next update holds ready high for 500 master clocks (20 clk each)
    task automatic t_hold();
        pulse(1'b0, 16'h1111);
        pulse(1'b0, 16'h2222);
        chk(data_ready_n, 1'b1);
        for (cnt = 0; cnt < 12000 && data_ready_n !== 1'b0; cnt++) begin
            @(posedge clk);
        end
        chk(cnt >= 9950 && cnt <= 10050, 1'b1);
        asp_host_model_inst.frame(8'h38, 16'h0000, 16, 1'b0, rx);
        chk(rx, 16'h2222);
    endtask : t_hold
    // Master clock output inverts the input at both levels
    task automatic t_mclk();
        @(posedge mclk_in);
        #200;
        chk(mclk_out, !mclk_in);
        @(negedge mclk_in);
        #200;
        chk(mclk_out, !mclk_in);
    endtask : t_mclk
    // Reset in mid-run: control back to power-on, interface waits for a command
    task automatic t_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk({data_ready_n, core_reset, ctrl, mclk_out}, 14'h3001);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({data_ready_n, core_reset, ctrl}, 13'h1000);
        t_read(16'h9696, 1'b0);
    endtask : t_reset
    initial begin
        #2000000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({data_ready_n, core_reset, ctrl}, 13'h1000);
        pulse(1'b1, 16'h0000);
        chk(data_ready_n, 1'b0);
        asp_host_model_inst.frame(8'h38, 16'h0000, 16, 1'b0, rx);
        chk(data_ready_n, 1'b1);
        t_read(16'hc3a5, 1'b0);
        t_read(16'h5a3c, 1'b1);
        t_hold();
        t_mclk();
        t_setup();
        t_reset();
        give_verdict();
    end
endmodule : adc_serial_port_ready_logic_tb
